// ---- hdl/bmps_cfg.svh ----
// Purpose: constants of the boot mode pin selector
// Assumes: 10 MHz clock, 64 sampled general purpose pins
// Notes: offsets are byte addresses of the plain register port
`ifndef BMPS_CFG_SVH
`define BMPS_CFG_SVH

// ****************************************
// register map
// ****************************************
`define BMPS_OFS_OTP_PIN 8'h00
`define BMPS_OFS_EMU_PIN 8'h04
`define BMPS_OFS_OTP_DEF_LO 8'h08
`define BMPS_OFS_OTP_DEF_HI 8'h0c
`define BMPS_OFS_EMU_DEF_LO 8'h10
`define BMPS_OFS_EMU_DEF_HI 8'h14
`define BMPS_OFS_CTRL 8'h18
`define BMPS_OFS_STATUS 8'h1c
`define BMPS_OFS_ACT_PIN 8'h20

// ****************************************
// fields and reset values
// ****************************************
`define BMPS_KEY_MSB 31
`define BMPS_KEY_LSB 24
`define BMPS_KEY 8'h5a
`define BMPS_OTP_ERASED 32'hffffffff
`define BMPS_EMU_RST 32'h00000000
`define BMPS_CTRL_EMU 0
`define BMPS_CTRL_RESTART 1
`define BMPS_GPIO_N 64

// ****************************************
// mode definition codes
// ****************************************
`define BMPS_CODE_SERIAL 5'h01
`define BMPS_CODE_FLASH 5'h03
`define BMPS_CODE_I2C 5'h07
`define BMPS_DEF_DEFAULT 32'h03210701
`define BMPS_FLASH_ENTRY 32'h00080000

// ****************************************
// pins
// ****************************************
`define BMPS_DEF_PIN0 8'h18
`define BMPS_DEF_PIN1 8'h20
`define BMPS_SER_RX_TABLE 32'h2212101c
`define BMPS_SER_TX_TABLE 32'h2313111d
`define BMPS_I2C_SDA 8'h20
`define BMPS_I2C_SCL 8'h21

// ****************************************
// timing
// ****************************************
`define BMPS_CLK_NS 100
`define BMPS_SETTLE_NS 1000
`define BMPS_SETTLE_CYC ((`BMPS_SETTLE_NS + `BMPS_CLK_NS - 1) / `BMPS_CLK_NS)

`endif

// ---- hdl/bmps_pkg.sv ----
// Purpose: types of the boot mode pin selector
// Assumes: constants live in bmps_cfg.svh
// Notes: none
`default_nettype none
package bmps_pkg;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_SETTLE = 4'h2,
        ST_DECIDE = 4'h4,
        ST_DONE = 4'h8
    } bmps_state_t;

    typedef enum logic [1:0] {
        SRC_NONE = 2'h0,
        SRC_FLASH = 2'h1,
        SRC_SERIAL = 2'h2,
        SRC_I2C = 2'h3
    } bmps_src_t;

endpackage
`default_nettype wire

// ---- hdl/bmps_sync.sv ----
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: inputs asynchronous to i_clk
// Notes: output follows once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module bmps_sync #(
    parameter int W = 64
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_stable
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= i_async;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // per bit: take the new level only when two stages agree
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_stable <= '0;
        end else begin
            o_stable <= (s2_r & s3_r) | (o_stable & (s2_r | s3_r));
        end
    end
endmodule
`default_nettype wire

// ---- hdl/bmps_top.sv ----
// Purpose: picks boot source from strap pins and configuration
// Assumes: plain register port, one clock, synchronous reset
// Notes: one time words accept a single write after reset
`timescale 1ns/100ps
`default_nettype none
`include "bmps_cfg.svh"
module bmps_top
    import bmps_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [`BMPS_GPIO_N-1:0] i_gpio,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    output logic o_boot_done,
    output logic [1:0] o_boot_src,
    output logic [2:0] o_boot_mode,
    output logic [31:0] o_entry_addr,
    output logic o_jump,
    output logic [7:0] o_pin_a,
    output logic [7:0] o_pin_b
);

    // ****************************************
    // pin synchroniser
    // ****************************************
    logic [`BMPS_GPIO_N-1:0] gpio_s;

    bmps_sync #(
        .W(`BMPS_GPIO_N)
    ) u_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_async(i_gpio),
        .o_stable(gpio_s)
    );

    function automatic logic pin_at(
        input logic [`BMPS_GPIO_N-1:0] v,
        input logic [7:0] idx
    );
        logic r;
        r = 1'b0;
        if (idx < 8'(`BMPS_GPIO_N)) begin
            r = v[idx[5:0]];
        end
        return r;
    endfunction

    // ****************************************
    // configuration registers
    // ****************************************
    logic [31:0] otp_pin_r;
    logic [31:0] emu_pin_r;
    logic [63:0] otp_def_r;
    logic [63:0] emu_def_r;
    logic otp_pin_lock_r;
    logic otp_def_lo_lock_r;
    logic otp_def_hi_lock_r;
    logic use_emu_r;
    logic restart_r;

    logic wr_otp_pin;
    logic wr_otp_lo;
    logic wr_otp_hi;

    assign wr_otp_pin = i_wr && i_addr == `BMPS_OFS_OTP_PIN;
    assign wr_otp_lo = i_wr && i_addr == `BMPS_OFS_OTP_DEF_LO;
    assign wr_otp_hi = i_wr && i_addr == `BMPS_OFS_OTP_DEF_HI;

    // one time words: first write sticks until reset
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            otp_pin_r <= `BMPS_OTP_ERASED;
            otp_pin_lock_r <= 1'b0;
        end else if (wr_otp_pin && !otp_pin_lock_r) begin
            otp_pin_r <= i_wdata;
            otp_pin_lock_r <= 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            otp_def_r <= {`BMPS_OTP_ERASED, `BMPS_OTP_ERASED};
            otp_def_lo_lock_r <= 1'b0;
            otp_def_hi_lock_r <= 1'b0;
        end else begin
            if (wr_otp_lo && !otp_def_lo_lock_r) begin
                otp_def_r[31:0] <= i_wdata;
                otp_def_lo_lock_r <= 1'b1;
            end
            if (wr_otp_hi && !otp_def_hi_lock_r) begin
                otp_def_r[63:32] <= i_wdata;
                otp_def_hi_lock_r <= 1'b1;
            end
        end
    end

    // emulation copies, freely writable
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            emu_pin_r <= `BMPS_EMU_RST;
        end else if (i_wr && (i_addr == `BMPS_OFS_EMU_PIN ||
                              i_addr == `BMPS_OFS_ACT_PIN)) begin
            emu_pin_r <= i_wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            emu_def_r <= {`BMPS_EMU_RST, `BMPS_EMU_RST};
        end else if (i_wr && i_addr == `BMPS_OFS_EMU_DEF_LO) begin
            emu_def_r[31:0] <= i_wdata;
        end else if (i_wr && i_addr == `BMPS_OFS_EMU_DEF_HI) begin
            emu_def_r[63:32] <= i_wdata;
        end
    end

    // control: copy select level, restart pulse
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            use_emu_r <= 1'b0;
            restart_r <= 1'b0;
        end else begin
            restart_r <= 1'b0;
            if (i_wr && i_addr == `BMPS_OFS_CTRL) begin
                use_emu_r <= i_wdata[`BMPS_CTRL_EMU];
                restart_r <= i_wdata[`BMPS_CTRL_RESTART];
            end
        end
    end

    // ****************************************
    // mode decode
    // ****************************************
    logic [31:0] act_pin;
    logic [63:0] act_def;
    logic custom_ok;
    logic [2:0] mode_nxt;
    logic [7:0] def_byte;
    logic [4:0] def_code;
    logic [1:0] ser_opt;
    bmps_src_t src_nxt;
    logic [7:0] pin_a_nxt;
    logic [7:0] pin_b_nxt;

    assign act_pin = use_emu_r ? emu_pin_r : otp_pin_r;
    assign act_def = use_emu_r ? emu_def_r : otp_def_r;

    assign custom_ok = act_pin[`BMPS_KEY_MSB:`BMPS_KEY_LSB] == `BMPS_KEY;

    always_comb begin
        if (custom_ok) begin
            mode_nxt = {pin_at(gpio_s, act_pin[23:16]),
                        pin_at(gpio_s, act_pin[15:8]),
                        pin_at(gpio_s, act_pin[7:0])};
        end else begin
            mode_nxt = {1'b0,
                        pin_at(gpio_s, `BMPS_DEF_PIN1),
                        pin_at(gpio_s, `BMPS_DEF_PIN0)};
        end
    end

    // default set: 11 flash, x0 serial, 01 i2c
    always_comb begin
        if (custom_ok) begin
            def_byte = act_def[{mode_nxt, 3'h0} +: 8];
        end else begin
            def_byte = 8'(`BMPS_DEF_DEFAULT >> {mode_nxt[1:0], 3'h0});
        end
    end

    assign def_code = def_byte[4:0];
    assign ser_opt = def_byte[6:5];

    always_comb begin
        src_nxt = SRC_NONE;
        pin_a_nxt = 8'h00;
        pin_b_nxt = 8'h00;
        case (def_code)
            `BMPS_CODE_SERIAL: begin
                src_nxt = SRC_SERIAL;
                pin_a_nxt = 8'(`BMPS_SER_RX_TABLE >> {ser_opt, 3'h0});
                pin_b_nxt = 8'(`BMPS_SER_TX_TABLE >> {ser_opt, 3'h0});
            end
            `BMPS_CODE_FLASH: begin
                src_nxt = SRC_FLASH;
            end
            `BMPS_CODE_I2C: begin
                src_nxt = SRC_I2C;
                pin_a_nxt = `BMPS_I2C_SDA;
                pin_b_nxt = `BMPS_I2C_SCL;
            end
            default: begin
                src_nxt = SRC_NONE;
            end
        endcase
    end

    // ****************************************
    // boot sequence
    // ****************************************
    localparam logic [7:0] SETTLE_CYC = 8'(`BMPS_SETTLE_CYC);

    bmps_state_t state_r;
    bmps_state_t state_nxt;
    logic [7:0] wait_r;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                state_nxt = ST_SETTLE;
            end
            ST_SETTLE: begin
                if (wait_r == SETTLE_CYC) begin
                    state_nxt = ST_DECIDE;
                end
            end
            ST_DECIDE: begin
                state_nxt = ST_DONE;
            end
            ST_DONE: begin
                if (restart_r) begin
                    state_nxt = ST_SETTLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // settle time lets the pin filter fill before sampling
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wait_r <= 8'h00;
        end else if (state_r == ST_SETTLE) begin
            wait_r <= wait_r + 8'h01;
        end else begin
            wait_r <= 8'h00;
        end
    end

    // ****************************************
    // decision outputs
    // ****************************************
    logic custom_r;
    logic err_r;
    logic [1:0] opt_r;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_boot_src <= SRC_NONE;
            o_boot_mode <= 3'h0;
            o_pin_a <= 8'h00;
            o_pin_b <= 8'h00;
            o_entry_addr <= 32'h00000000;
            custom_r <= 1'b0;
            err_r <= 1'b0;
            opt_r <= 2'h0;
        end else if (state_r == ST_DECIDE) begin
            o_boot_src <= src_nxt;
            o_boot_mode <= mode_nxt;
            o_pin_a <= pin_a_nxt;
            o_pin_b <= pin_b_nxt;
            custom_r <= custom_ok;
            err_r <= src_nxt == SRC_NONE;
            opt_r <= ser_opt;
            if (src_nxt == SRC_FLASH) begin
                o_entry_addr <= `BMPS_FLASH_ENTRY;
            end else begin
                o_entry_addr <= 32'h00000000;
            end
        end
    end

    // done level and one cycle jump to the flash entry
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_boot_done <= 1'b0;
            o_jump <= 1'b0;
        end else begin
            o_boot_done <= state_nxt == ST_DONE;
            o_jump <= state_r == ST_DECIDE && src_nxt == SRC_FLASH;
        end
    end

    // ****************************************
    // register read
    // ****************************************
    logic [31:0] status;
    logic [31:0] rd_nxt;

    assign status = {20'h00000, err_r, otp_def_hi_lock_r && otp_def_lo_lock_r,
                     otp_pin_lock_r, opt_r, o_boot_mode, o_boot_src,
                     custom_r, o_boot_done};

    always_comb begin
        case (i_addr)
            `BMPS_OFS_OTP_PIN: rd_nxt = otp_pin_r;
            `BMPS_OFS_EMU_PIN: rd_nxt = emu_pin_r;
            `BMPS_OFS_OTP_DEF_LO: rd_nxt = otp_def_r[31:0];
            `BMPS_OFS_OTP_DEF_HI: rd_nxt = otp_def_r[63:32];
            `BMPS_OFS_EMU_DEF_LO: rd_nxt = emu_def_r[31:0];
            `BMPS_OFS_EMU_DEF_HI: rd_nxt = emu_def_r[63:32];
            `BMPS_OFS_CTRL: rd_nxt = {31'h00000000, use_emu_r};
            `BMPS_OFS_STATUS: rd_nxt = status;
            `BMPS_OFS_ACT_PIN: rd_nxt = act_pin;
            default: rd_nxt = 32'h00000000;
        endcase
    end

    // data stands only in the cycle after the read strobe
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_rdata <= 32'h00000000;
        end else if (i_rd) begin
            o_rdata <= rd_nxt;
        end else begin
            o_rdata <= 32'h00000000;
        end
    end

endmodule
`default_nettype wire

// ---- bench/bmps_strap.sv ----
// Purpose: board strapping model driving the boot select pins
// Assumes: levels chosen by the bench
// Notes: optional bounce shows inverted levels for three cycles
`timescale 1ns/100ps
`default_nettype none
module bmps_strap (
    input wire logic i_clk,
    input wire logic [63:0] i_level,
    input wire logic i_bounce,
    output logic [63:0] o_gpio
);
    logic [63:0] last_r = 64'h0;
    logic [1:0] cnt_r = 2'h0;
    always @(posedge i_clk) begin
        last_r <= i_level;
        if (i_level != last_r && i_bounce) begin
            cnt_r <= 2'h3;
        end else if (cnt_r != 2'h0) begin
            cnt_r <= cnt_r - 2'h1;
        end
    end
    // slow strap: contacts settle late
    assign o_gpio = (cnt_r != 2'h0) ? ~i_level : i_level;
endmodule
`default_nettype wire

// ---- bench/bmps_chk.sv ----
// Purpose: port checker of the boot mode pin selector
// Assumes: one clock, synchronous reset
// Notes: bound to bmps_top
`timescale 1ns/100ps
`default_nettype none
module bmps_chk (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [63:0] i_gpio,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic o_boot_done,
    input wire logic [1:0] o_boot_src,
    input wire logic [2:0] o_boot_mode,
    input wire logic [31:0] o_entry_addr,
    input wire logic o_jump,
    input wire logic [7:0] o_pin_a,
    input wire logic [7:0] o_pin_b
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence s_settle;
        !o_boot_done[*8] ##1 !o_boot_done[*5];
    endsequence
    sequence s_restart;
        i_wr && i_addr == 8'h18 && i_wdata[1] && o_boot_done;
    endsequence
    a_boot_time: assert property ($fell(i_rst) |-> s_settle ##[1:2] o_boot_done)
        else $error("boot decision not on time");
    a_restart_run: assert property (s_restart |-> ##[2:3] !o_boot_done)
        else $error("restart not taken");
    a_jump_flash: assert property (o_jump |-> o_boot_src == 2'h1 && o_boot_done)
        else $error("jump without flash decision");
    a_jump_rise: assert property ($rose(o_boot_done) |-> o_jump == (o_boot_src == 2'h1))
        else $error("jump not with flash decision");
    a_jump_pulse: assert property (o_jump |=> !o_jump)
        else $error("jump longer than one cycle");
    a_entry_addr: assert property (
        o_entry_addr == ((o_boot_src == 2'h1) ? 32'h00080000 : 32'h0))
        else $error("entry address wrong");
    a_i2c_pins: assert property (o_boot_src == 2'h3 |->
        o_pin_a == 8'h20 && o_pin_b == 8'h21)
        else $error("i2c pins wrong");
    a_serial_pins: assert property (o_boot_src == 2'h2 |->
        {o_pin_a, o_pin_b} inside {16'h1c1d, 16'h1011, 16'h1213, 16'h2223})
        else $error("serial pin pair wrong");
    a_decision_hold: assert property ($past(o_boot_done) && o_boot_done |->
        $stable(o_boot_src) && $stable(o_boot_mode) && $stable(o_pin_a))
        else $error("decision changed while held");
    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
        else $error("read data outside read cycle");
endmodule
bind bmps_top bmps_chk u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_gpio(i_gpio), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_boot_done(o_boot_done),
    .o_boot_src(o_boot_src), .o_boot_mode(o_boot_mode), .o_entry_addr(o_entry_addr),
    .o_jump(o_jump), .o_pin_a(o_pin_a), .o_pin_b(o_pin_b));
`default_nettype wire

// ---- bench/boot_mode_pin_select_tb_top.sv ----
// Purpose: self-checking bench of the boot mode pin selector
// Assumes: strap model drives the pins
// Notes: fixed seed, expectations from bench functions
`timescale 1ns/100ps
`default_nettype none
`include "bmps_cfg.svh"
module boot_mode_pin_select_tb_top;
    logic clk, rst, wr, rd, bnc, done, jump;
    logic [63:0] lvl, gpio;
    logic [7:0] addr, pa, pb;
    logic [31:0] wdata, rdata, entry;
    logic [1:0] src;
    logic [2:0] mode;
    int n_mismatch = 0;
    int compares = 0;
    bmps_strap u_strap (.i_clk(clk), .i_level(lvl), .i_bounce(bnc), .o_gpio(gpio));
    bmps_top dut (.i_clk(clk), .i_rst(rst), .i_gpio(gpio), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_boot_done(done), .o_boot_src(src),
        .o_boot_mode(mode), .o_entry_addr(entry), .o_jump(jump), .o_pin_a(pa), .o_pin_b(pb));
    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end
    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input string nm);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        @(negedge clk);
        chk(nm, rdata, e);
    endtask
    function automatic logic [49:0] dec(input logic [7:0] b);
        logic [31:0] rx, tx;
        rx = `BMPS_SER_RX_TABLE >> {b[6:5], 3'h0};
        tx = `BMPS_SER_TX_TABLE >> {b[6:5], 3'h0};
        case (b[4:0])
            5'h01: dec = {2'h2, rx[7:0], tx[7:0], 32'h0};
            5'h03: dec = {2'h1, 16'h0, 32'h00080000};
            5'h07: dec = {2'h3, 8'h20, 8'h21, 32'h0};
            default: dec = 50'h0;
        endcase
    endfunction
    task automatic wait_done;
        int i;
        i = 0;
        while (done !== 1'h1 && i < 60) begin
            @(negedge clk);
            i++;
        end
        if (i == 60) begin
            chk("done", 32'h0, 32'h1);
        end
    endtask
    task automatic boot(input logic [63:0] p, input logic [31:0] ctl, input logic [2:0] m,
        input logic [7:0] b);
        logic [49:0] e;
        e = dec(b);
        @(posedge clk);
        lvl <= p;
        bnc <= 1'($urandom);
        wr_reg(8'h18, ctl | 32'h2);
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("busy", 32'(done), 32'h0);
        wait_done;
        chk("jump", 32'(jump), 32'(e[49:48] == 2'h1));
        chk("src", 32'(src), 32'(e[49:48]));
        chk("mode", 32'(mode), 32'(m));
        chk("pin_a", 32'(pa), 32'(e[47:40]));
        chk("pin_b", 32'(pb), 32'(e[39:32]));
        chk("entry", entry, e[31:0]);
    endtask
    task automatic wrap_up;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        logic [63:0] p;
        logic [7:0] f0, f1, f2;
        logic [31:0] lo, hi;
        rst = 1'h1;
        wr = 1'h0;
        rd = 1'h0;
        bnc = 1'h0;
        addr = 8'h0;
        wdata = 32'h0;
        void'($urandom(37947));
        lvl = {$urandom, $urandom} | (64'h1 << 24) | (64'h1 << 32);
        repeat (16) @(posedge clk);
        rst <= 1'h0;
        wait_done;
        chk("src", 32'(src), 32'h1);
        rd_reg(8'h00, 32'hffffffff, "otp_pin");
        rd_reg(8'h10, 32'h0, "emu_def");
        rd_reg(8'h40, 32'h0, "unmapped");
        for (int i = 0; i < 4; i++) begin
            p = {$urandom, $urandom};
            p[24] = i[0];
            p[32] = i[1];
            boot(p, 32'h0, i[2:0], 8'(`BMPS_DEF_DEFAULT >> (8 * i)));
        end
        f0 = 8'($urandom % 21);
        f1 = 8'(21 + $urandom % 21);
        f2 = 8'(42 + $urandom % 22);
        lo = 32'h03610100;
        hi = 32'h07071f41;
        wr_reg(8'h04, {8'h5a, f2, f1, f0});
        wr_reg(8'h10, lo);
        wr_reg(8'h14, hi);
        rd_reg(8'h14, hi, "emu_def_hi");
        for (int m = 0; m < 8; m++) begin
            p = {$urandom, $urandom};
            {p[f2], p[f1], p[f0]} = m[2:0];
            boot(p, 32'h1, m[2:0], 8'({hi, lo} >> (8 * m)));
        end
        wr_reg(8'h20, {8'h5b, f2, f1, f0});
        rd_reg(8'h04, {8'h5b, f2, f1, f0}, "emu_pin");
        p = {$urandom, $urandom};
        p[24] = 1'h1;
        p[32] = 1'h0;
        boot(p, 32'h1, 3'h1, 8'h07);
        rd_reg(8'h1c, 32'h0000001d, "status");
        rd_reg(8'h18, 32'h00000001, "ctrl");
        wr_reg(8'h00, {8'h5a, f2, f1, f0});
        wr_reg(8'h00, 32'h0);
        rd_reg(8'h00, {8'h5a, f2, f1, f0}, "otp_once");
        wr_reg(8'h08, lo);
        p = {$urandom, $urandom};
        {p[f2], p[f1], p[f0]} = 3'h3;
        boot(p, 32'h0, 3'h3, 8'h03);
        rd_reg(8'h20, {8'h5a, f2, f1, f0}, "active");
        rd_reg(8'h1c, 32'h00000237, "status_otp");
        wrap_up;
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        wrap_up;
    end
endmodule
`default_nettype wire
